// ### gpb_bank.sv
// Windowed general register bank over internal RAM
// How it works
// - Bank base comes from the base pointer
// - Bank addresses always wrap inside internal RAM
// - Word register n lives at base plus 2n
// - Short codes F0 to FF select words
// - Every bit readable, settable and clearable
// - Bytes only for the lower eight words
// - Low byte at base+2n, high at +1
// - Byte write leaves the other half alone
// - Reset keeps RAM contents but clears the base pointer
`timescale 1ns/100ps
`include "gpb_defs.svh"

module gpb_bank (
  input logic sys_clk,
  input logic nrst,
  input logic cp_wr,
  input logic [15:0] cp_wdata,
  input gpb_pkg::gpb_req_t gp_req,
  input gpb_pkg::gpb_mem_t mem_req,
  output logic [15:0] bank_base_pointer_r,
  output gpb_pkg::gpb_rsp_t gp_rsp_r,
  output gpb_pkg::gpb_rsp_t mem_rsp_r
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Word slot of register n; the sum wraps so it never leaves RAM
  function automatic logic [9:0] slot_of(input logic [9:0] base,
                                         input logic [3:0] n);
    slot_of = base + {6'h00, n};
  endfunction

  // Short code is legal only in the top sixteen codes
  function automatic logic code_ok(input logic [7:0] code);
    code_ok = (code[7:4] == `GPB_SHORT_HI);
  endfunction

  // One-hot mask for a bit position
  function automatic logic [15:0] bit_mask(input logic [3:0] idx);
    bit_mask = `GPB_BIT_ONE << idx;
  endfunction

  // ****************************************************************
  // Request decode
  // ****************************************************************
  logic [9:0] cp_idx; // Bank base as a word index
  logic [3:0] code_n; // Register or byte number from the code
  logic is_byte; // Byte-wide operand
  logic legal; // Code falls in the bank window
  logic [9:0] gp_addr; // RAM word touched by the operand
  logic [15:0] gp_old; // Current RAM word at gp_addr
  logic gp_we; // Register side writes this cycle
  logic [1:0] gp_be; // Lanes written by the register side
  logic [15:0] gp_wd; // Data written by the register side
  logic [15:0] gp_rd; // Answer data before the flop
  logic [15:0] mem_old; // Current RAM word for memory side
  logic mem_we; // Memory side writes this cycle

  assign cp_idx = bank_base_pointer_r[10:1];
  assign code_n = gp_req.short_addr[3:0];
  assign legal = code_ok(gp_req.short_addr);
  assign is_byte = (gp_req.op == gpb_pkg::GPB_BYTE_RD) ||
                   (gp_req.op == gpb_pkg::GPB_BYTE_WR);

  // Byte code k picks register k/2; this caps bytes at word seven
  always_comb
  begin
    if (is_byte)
      gp_addr = slot_of(cp_idx, {1'b0, code_n[3:1]});
    else
      gp_addr = slot_of(cp_idx, code_n);
  end

  // Write and answer formation per operand kind
  always_comb
  begin
    gp_we = 1'b0;
    gp_be = 2'b11;
    gp_wd = gp_old;
    gp_rd = `GPB_WORD_ZERO;
    case (gp_req.op)
      // Whole word
      gpb_pkg::GPB_WORD_RD:
        gp_rd = gp_old;
      gpb_pkg::GPB_WORD_WR:
      begin
        gp_we = 1'b1;
        gp_wd = gp_req.wdata;
      end
      // Byte read: selected half lands in the low byte
      gpb_pkg::GPB_BYTE_RD:
        gp_rd = {8'h00, code_n[0] ? gp_old[15:8] : gp_old[7:0]};
      // Byte write: only one lane enabled
      gpb_pkg::GPB_BYTE_WR:
      begin
        gp_we = 1'b1;
        gp_be = code_n[0] ? 2'b10 : 2'b01;
        gp_wd = {gp_req.wdata[7:0], gp_req.wdata[7:0]};
      end
      // Bit set and clear read-modify-write the whole word; bit read only reads
      gpb_pkg::GPB_BIT_RD:
        gp_rd = {15'h0000, gp_old[gp_req.bit_idx]};
      gpb_pkg::GPB_BIT_SET:
      begin
        gp_we = 1'b1;
        gp_wd = gp_old | bit_mask(gp_req.bit_idx);
        gp_rd = {15'h0000, gp_old[gp_req.bit_idx]};
      end
      gpb_pkg::GPB_BIT_CLR:
      begin
        gp_we = 1'b1;
        gp_wd = gp_old & ~bit_mask(gp_req.bit_idx);
        gp_rd = {15'h0000, gp_old[gp_req.bit_idx]};
      end
      default:
        gp_rd = `GPB_WORD_ZERO;
    endcase
  end

  assign mem_we = mem_req.valid && mem_req.wr;

  // ****************************************************************
  // Shared storage
  // ****************************************************************
  // One array serves both views, so neither can go stale
  gpb_ram u_ram (
    .sys_clk(sys_clk),
    .a_we(gp_req.valid && legal && gp_we),
    .a_addr(gp_addr),
    .a_be(gp_be),
    .a_wdata(gp_wd),
    .a_rdata(gp_old),
    .b_we(mem_we),
    .b_addr(mem_req.addr[10:1]),
    .b_be(mem_req.be),
    .b_wdata(mem_req.wdata),
    .b_rdata(mem_old)
  );
  // The array has no reset input at all

  // ****************************************************************
  // Bank base pointer
  // ****************************************************************
  // Masked to a word inside internal RAM; outer bits are dropped
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      bank_base_pointer_r <= `GPB_CP_RST;
    else if (cp_wr)
      bank_base_pointer_r <= cp_wdata & `GPB_CP_MASK;
  end

  // ****************************************************************
  // Answers
  // ****************************************************************
  // Register answer one cycle after the request; bad codes flag err
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      gp_rsp_r <= '0;
    else
    begin
      gp_rsp_r.valid <= gp_req.valid;
      gp_rsp_r.err <= gp_req.valid && !legal;
      gp_rsp_r.data <= (gp_req.valid && legal) ? gp_rd
                                               : `GPB_WORD_ZERO;
    end
  end

  // Memory answer shows the word before this cycle's writes
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      mem_rsp_r <= '0;
    else
    begin
      mem_rsp_r.valid <= mem_req.valid;
      mem_rsp_r.err <= 1'b0;
      mem_rsp_r.data <= (mem_req.valid && !mem_req.wr) ? mem_old
                                                       : `GPB_WORD_ZERO;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // Checks that look into the array go through the RAM instance.
  // The register port wins every collision there, so a register
  // write can be checked without ruling out the memory side.
  // Checks that start on one request and end on a later one assume
  // the core spacing of one idle cycle between operations.

  chk_base_load: assert property (
    cp_wr |=> bank_base_pointer_r == ($past(cp_wdata) & `GPB_CP_MASK))
    else $error("base pointer not loaded");

  chk_base_inside: assert property (
    (bank_base_pointer_r & ~`GPB_CP_MASK) == `GPB_WORD_ZERO)
    else $error("base pointer escapes internal RAM");

  chk_word_map: assert property (
    gp_req.valid && !is_byte |-> gp_addr == cp_idx + {6'h00, code_n})
    else $error("word register mapped wrong");

  chk_bad_code: assert property (
    gp_req.valid && !legal |=> gp_rsp_r.valid && gp_rsp_r.err)
    else $error("illegal short code not flagged");

  chk_bit_set: assert property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_BIT_SET
    |=> u_ram.mem[$past(gp_addr)][$past(gp_req.bit_idx)] == 1'b1)
    else $error("set bit not stored as one");

  // A cleared bit must land as zero in the word
  chk_bit_clr: assert property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_BIT_CLR
    |=> u_ram.mem[$past(gp_addr)][$past(gp_req.bit_idx)] == 1'b0)
    else $error("cleared bit not stored as zero");

  // Bit read and bit set answer the old bit in bit zero only
  chk_bit_old: assert property (
    gp_req.valid && legal && gp_req.op[2:1] == 2'b11
    |=> gp_rsp_r.data == (16'h0001 &
    ($past(gp_old) >> $past(gp_req.bit_idx))))
    else $error("bit operation answered wrong bit");

  chk_byte_low8: assert property (
    gp_req.valid && is_byte |-> (10'(gp_addr - cp_idx)) < 10'd8)
    else $error("byte access beyond word seven");

  chk_byte_lane: assert property (
    gp_req.valid && gp_req.op == gpb_pkg::GPB_BYTE_WR |->
    gp_be == (code_n[0] ? 2'b10 : 2'b01))
    else $error("byte lane chosen wrong");

  chk_byte_keep: assert property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_BYTE_WR &&
    !mem_we |=> (u_ram.mem[$past(gp_addr)] & ~{{8{$past(code_n[0])}},
    {8{!$past(code_n[0])}}}) == ($past(gp_old) &
    ~{{8{$past(code_n[0])}}, {8{!$past(code_n[0])}}}))
    else $error("byte write disturbed other half");

  // A register word write is seen by a plain read two cycles later,
  // provided nothing else touched the bank in between
  chk_coherent: assert property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_WORD_WR ##2
    mem_req.valid && !mem_req.wr &&
    mem_req.addr[10:1] == $past(gp_addr, 2) && !$past(mem_we) &&
    !$past(gp_req.valid)
    |=> mem_rsp_r.data == $past(gp_req.wdata, 3))
    else $error("memory view stale after register write");

  // A word write lands whole at its slot
  chk_word_store: assert property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_WORD_WR
    |=> u_ram.mem[$past(gp_addr)] == $past(gp_req.wdata))
    else $error("word write not stored");

  // A refused code must leave the addressed word alone
  chk_bad_keep: assert property (
    gp_req.valid && !legal && !mem_we
    |=> u_ram.mem[$past(gp_addr)] == $past(gp_old))
    else $error("refused code wrote the bank");

  // A refused code answers no data
  chk_bad_zero: assert property (
    gp_req.valid && !legal |=> gp_rsp_r.data == `GPB_WORD_ZERO)
    else $error("refused code answered data");

  // A byte read fills only the low byte of the answer
  chk_byte_hi_zero: assert property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_BYTE_RD
    |=> gp_rsp_r.data[15:8] == 8'h00)
    else $error("byte read upper half not zero");

  // Memory answers follow requests by one cycle, never flagged
  chk_mem_answer: assert property (
    mem_rsp_r.valid == $past(mem_req.valid) && !mem_rsp_r.err)
    else $error("memory answer timing wrong");

  // The pointer only moves on a load
  chk_base_hold: assert property (
    !cp_wr |=> $stable(bank_base_pointer_r))
    else $error("base pointer moved without a load");

  // Register answers follow requests by exactly one cycle
  chk_rsp_pulse: assert property (
    gp_rsp_r.valid == $past(gp_req.valid))
    else $error("register answer timing wrong");

  cov_word_wr: cover property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_WORD_WR);
  cov_byte_hi: cover property (
    gp_req.valid && gp_req.op == gpb_pkg::GPB_BYTE_WR && code_n[0]);
  cov_bit_clr: cover property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_BIT_CLR);
  cov_relocate: cover property (cp_wr ##1 gp_req.valid && legal);
  cov_coherent: cover property (
    gp_req.valid && legal && gp_req.op == gpb_pkg::GPB_WORD_WR ##2
    mem_req.valid && !mem_req.wr);

endmodule

// ### gpb_core_model.sv
// CPU core model issuing register, memory and pointer operations
`timescale 1ns/100ps

module gpb_core_model (
  input logic sys_clk,
  output gpb_pkg::gpb_req_t gp_req,
  output gpb_pkg::gpb_mem_t mem_req,
  output logic cp_wr,
  output logic [15:0] cp_wdata,
  input gpb_pkg::gpb_rsp_t gp_rsp_r,
  input gpb_pkg::gpb_rsp_t mem_rsp_r
);
  // ****************************************************************
  // Idle bus at time zero
  // ****************************************************************
  initial
  begin
    gp_req = '0;
    mem_req = '0;
    cp_wr = 1'b0;
    cp_wdata = 16'h0000;
  end

  // ****************************************************************
  // Operation tasks
  // ****************************************************************
  // Polls a few falling edges so either answer latency is caught
  task automatic wait_rsp(input logic sel, output gpb_pkg::gpb_rsp_t r);
    r = '0;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge sys_clk);
      if ((sel ? mem_rsp_r.valid : gp_rsp_r.valid) === 1'b1)
      begin
        r = sel ? mem_rsp_r : gp_rsp_r;
        break;
      end
    end
  endtask

  // One register operand, held until the edge that takes it
  task automatic reg_op(input gpb_pkg::gpb_op_t op, input logic [7:0] code,
    input logic [3:0] bi, input logic [15:0] wd,
    output gpb_pkg::gpb_rsp_t r);
    @(posedge sys_clk);
    gp_req <= '{1'b1, op, code, bi, wd};
    @(posedge sys_clk);
    gp_req.valid <= 1'b0;
    wait_rsp(1'b0, r);
  endtask

  // One plain word access on internal RAM, both lanes
  task automatic mem_op(input logic wr, input logic [10:0] a,
    input logic [15:0] wd, output gpb_pkg::gpb_rsp_t r);
    @(posedge sys_clk);
    mem_req <= '{1'b1, wr, a, 2'b11, wd};
    @(posedge sys_clk);
    mem_req.valid <= 1'b0;
    wait_rsp(1'b1, r);
  endtask

  // Pointer load; waits past the edge so the new value has landed
  task automatic set_base(input logic [15:0] v);
    @(posedge sys_clk);
    cp_wr <= 1'b1;
    cp_wdata <= v;
    @(posedge sys_clk);
    cp_wr <= 1'b0;
    @(negedge sys_clk);
  endtask
endmodule

// ### gpb_defs.svh
// Constants for the windowed general register bank
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define GPB_RAM_WORDS 1024
`define GPB_RAM_AW 10
`define GPB_NREGS 16
`define GPB_NBYTE_REGS 8

// ****************************************************************
// Short register codes and pointer layout
// ****************************************************************
`define GPB_SHORT_HI 4'hF
`define GPB_CP_MASK 16'h07FE
`define GPB_CP_RST 16'h0000
`define GPB_WORD_ZERO 16'h0000
`define GPB_BIT_ONE 16'h0001

`endif

// ### gpb_pkg.sv
// Types shared by the general register bank, its core model and testbench
package gpb_pkg;

  // Operand access kinds issued by the core
  typedef enum logic [2:0] {
    GPB_WORD_RD = 3'h0,
    GPB_WORD_WR = 3'h1,
    GPB_BYTE_RD = 3'h3,
    GPB_BYTE_WR = 3'h2,
    GPB_BIT_RD = 3'h6,
    GPB_BIT_SET = 3'h7,
    GPB_BIT_CLR = 3'h5
  } gpb_op_t;

  // Register operand request, addressed by short code
  typedef struct packed {
    logic valid;
    gpb_op_t op;
    logic [7:0] short_addr;
    logic [3:0] bit_idx;
    logic [15:0] wdata;
  } gpb_req_t;

  // Plain internal RAM request, byte address
  typedef struct packed {
    logic valid;
    logic wr;
    logic [10:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } gpb_mem_t;

  // Answer to either request
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } gpb_rsp_t;

endpackage

// ### gpb_ram.sv
// Internal RAM array with two byte-lane write ports and two read ports
`timescale 1ns/100ps
`include "gpb_defs.svh"

module gpb_ram (
  input logic sys_clk,
  input logic a_we,
  input logic [9:0] a_addr,
  input logic [1:0] a_be,
  input logic [15:0] a_wdata,
  output logic [15:0] a_rdata,
  input logic b_we,
  input logic [9:0] b_addr,
  input logic [1:0] b_be,
  input logic [15:0] b_wdata,
  output logic [15:0] b_rdata
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // No reset on purpose: contents survive a reset
  logic [15:0] mem [`GPB_RAM_WORDS];

  // Asynchronous reads give the read-modify-write path its old value
  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];

  // ****************************************************************
  // Byte lanes
  // ****************************************************************
  // One process owns the whole array, since two processes may not
  // share it; port a is written last so the register side wins
  always_ff @(posedge sys_clk)
  begin
    for (int lane = 0; lane < 2; lane++)
    begin
      if (b_we && b_be[lane])
        mem[b_addr][lane*8 +: 8] <= b_wdata[lane*8 +: 8];
      if (a_we && a_be[lane])
        mem[a_addr][lane*8 +: 8] <= a_wdata[lane*8 +: 8];
    end
  end

endmodule

// ### tb.sv
// Self-checking testbench for the windowed general register bank
`timescale 1ns/100ps

module tb;
  logic sys_clk;
  logic nrst;
  gpb_pkg::gpb_req_t gp_req;
  gpb_pkg::gpb_mem_t mem_req;
  logic cp_wr;
  logic [15:0] cp_wdata;
  logic [15:0] bank_base_pointer_r;
  gpb_pkg::gpb_rsp_t gp_rsp_r;
  gpb_pkg::gpb_rsp_t mem_rsp_r;
  gpb_pkg::gpb_rsp_t r; // Last answer seen
  int n_mismatch;
  int total_checks;
  // Short aliases for the operand kinds
  localparam gpb_pkg::gpb_op_t WW = gpb_pkg::GPB_WORD_WR;
  localparam gpb_pkg::gpb_op_t WR = gpb_pkg::GPB_WORD_RD;
  localparam gpb_pkg::gpb_op_t BW = gpb_pkg::GPB_BYTE_WR;
  localparam gpb_pkg::gpb_op_t BR = gpb_pkg::GPB_BYTE_RD;

  gpb_bank gpb_bank_i (.sys_clk(sys_clk), .nrst(nrst), .cp_wr(cp_wr),
    .cp_wdata(cp_wdata), .gp_req(gp_req), .mem_req(mem_req),
    .bank_base_pointer_r(bank_base_pointer_r), .gp_rsp_r(gp_rsp_r),
    .mem_rsp_r(mem_rsp_r));

  gpb_core_model gpb_core_model_i (.sys_clk(sys_clk), .gp_req(gp_req),
    .mem_req(mem_req), .cp_wr(cp_wr), .cp_wdata(cp_wdata),
    .gp_rsp_r(gp_rsp_r), .mem_rsp_r(mem_rsp_r));

  // ****************************************************************
  // Clock and helpers
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Four-state compare so an unknown never passes
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic go(input gpb_pkg::gpb_op_t op, input logic [7:0] code,
    input logic [3:0] bi, input logic [15:0] wd);
    gpb_core_model_i.reg_op(op, code, bi, wd, r);
  endtask

  task automatic mem(input logic wr, input logic [10:0] a,
    input logic [15:0] wd);
    gpb_core_model_i.mem_op(wr, a, wd, r);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog; the full sequence needs well under 1000 cycles
  initial
  begin
    #40000;
    n_mismatch++;
    summarize();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    nrst = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    gpb_core_model_i.set_base(16'h0100);
    chk("base", 16'h0100, bank_base_pointer_r);
    // Fill all sixteen words, then read them back as plain RAM
    for (int n = 0; n < 16; n++)
      go(WW, 8'hF0 + n[7:0], 4'h0, 16'hA000 + n[15:0]);
    chk("word wr err", 16'h0000, {15'h0000, r.err});
    for (int n = 0; n < 16; n++)
    begin
      mem(1'b0, 11'h100 + n[10:0] * 11'h002, 16'h0000);
      chk("ram word", 16'hA000 + n[15:0], r.data);
    end
    chk("ram err", 16'h0000, {15'h0000, r.err});
    // Byte lanes; only the addressed half may change
    go(BW, 8'hF1, 4'h0, 16'h005A);
    go(WR, 8'hF0, 4'h0, 16'h0000);
    chk("word 0", 16'h5A00, r.data);
    go(BW, 8'hF2, 4'h0, 16'h003C);
    go(WR, 8'hF1, 4'h0, 16'h0000);
    chk("word 1", 16'hA03C, r.data);
    go(BW, 8'hFF, 4'h0, 16'h0077);
    mem(1'b0, 11'h10E, 16'h0000);
    chk("word 7", 16'h7707, r.data);
    go(WR, 8'hFF, 4'h0, 16'h0000);
    chk("word 15", 16'hA00F, r.data);
    go(BR, 8'hF1, 4'h0, 16'h0000);
    chk("byte 1", 16'h005A, r.data);
    // Bit operations on word 8, old bit answered in bit 0
    go(gpb_pkg::GPB_BIT_SET, 8'hF8, 4'h0, 16'h0000);
    chk("set old", 16'h0000, {15'h0000, r.data[0]});
    go(gpb_pkg::GPB_BIT_CLR, 8'hF8, 4'hF, 16'h0000);
    chk("clr old", 16'h0001, {15'h0000, r.data[0]});
    go(gpb_pkg::GPB_BIT_RD, 8'hF8, 4'hD, 16'h0000);
    chk("bit 13", 16'h0001, {15'h0000, r.data[0]});
    go(WR, 8'hF8, 4'h0, 16'h0000);
    chk("word 8", 16'h2009, r.data);
    // Code outside the bank is refused and writes nothing
    go(WW, 8'hE3, 4'h0, 16'hFFFF);
    chk("refused", 16'h0001, {15'h0000, r.err});
    chk("refused data", 16'h0000, r.data);
    go(WR, 8'hF3, 4'h0, 16'h0000);
    chk("word 3 untouched", 16'hA003, r.data);
    // Relocation and wrap inside internal RAM
    mem(1'b1, 11'h120, 16'hBEEF);
    gpb_core_model_i.set_base(16'h0120);
    go(WR, 8'hF0, 4'h0, 16'h0000);
    chk("moved word 0", 16'hBEEF, r.data);
    gpb_core_model_i.set_base(16'hFFFE);
    chk("base", 16'h07FE, bank_base_pointer_r);
    go(WW, 8'hF1, 4'h0, 16'h4242);
    mem(1'b0, 11'h000, 16'h0000);
    chk("wrapped", 16'h4242, r.data);
    // Reset in mid-run keeps the bank contents
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk("base", 16'h0000, bank_base_pointer_r);
    gpb_core_model_i.set_base(16'h0100);
    go(WR, 8'hF3, 4'h0, 16'h0000);
    chk("kept word 3", 16'hA003, r.data);
    summarize();
  end
endmodule
